//--- design/cts_txsel_ctrl.sv
// How it works
// R1: the selection register stays at reset while init request and acknowledge are both high.
// R2: the selection register takes writes only when init request and acknowledge are both low.
// R3: a read of the selection register shows only its lowest set bit.
// R4: the window maps the buffer of the lowest set selection bit, higher bits ignored.
// R5: window accesses are refused while the mapped buffer's empty flag is clear.
// R6: with no buffer selected every window access is refused.
// R7: software reads the flag register, writes it into the selection, and reads the selection back.
// R8: the acceptance control register is written only in init mode and read anytime.
// R9: the hit field is read-only to software.
// R10: organisation 00 is two 32-bit filters, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// R11: with the filter closed no message reloads the foreground buffer.
// R12: the hit field holds the binary index of the matching filter.
// R13: the hit field updates whenever a message moves into the foreground buffer.
// R14: an empty flag reads 0 while its buffer is scheduled and 1 while it is empty.
// R15: unimplemented bits read zero and ignore writes.
module cts_txsel_ctrl
  import cts_pkg::*;
#(
  parameter int WIN_WORDS = CTS_WIN_WORDS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // mode handshake from the controller core, same clock
  input  wire logic        init_request,
  input  wire logic        init_acknowledge,
  // transmit side: core sets flags on completion or abort
  input  wire logic [2:0]  tx_done,
  output logic [2:0]       tx_scheduled,
  // receive side: message moving into the foreground buffer
  input  wire logic        rx_valid,
  input  wire logic [2:0]  rx_hit,
  output logic             rx_load,
  output logic [1:0]       filter_organisation_field,
  output logic [1:0]       tbsel_mapped
);

  localparam int WA = $clog2(WIN_WORDS);

  logic [2:0]  tx_buffer_select_q;
  logic [2:0]  tx_buffer_empty_flag_q;
  logic [31:0] win_mem [3][WIN_WORDS];
  logic        init_mode;
  logic        run_mode;
  logic        req_wait;
  logic        access;
  logic [2:0]  sel_onehot;
  logic [1:0]  sel_idx;
  logic        win_hit;
  logic        win_ok;
  logic [WA-1:0] win_word;
  logic        org_we;
  logic [1:0]  org_q;
  logic [2:0]  hit_q;
  logic        rx_accept;
  logic [31:0] rd_d;
  logic        err_d;

  assign init_mode = init_request && init_acknowledge;
  assign run_mode  = !init_request && !init_acknowledge;
  // decode while the request waits for its answer; pready rises one cycle after psel
  assign req_wait  = psel && !pready;
  // writes land only at the edge where the master samples pready high, so a
  // frozen clock enable can stretch a transfer without losing or doubling it
  assign access    = psel && penable && pready;

  // mapped buffer is the lowest set selection bit
  assign sel_onehot = cts_lowest(tx_buffer_select_q);  // R4
  always_comb begin
    sel_idx = 2'h0;
    if (sel_onehot[1]) begin
      sel_idx = 2'h1;
    end else if (sel_onehot[2]) begin
      sel_idx = 2'h2;
    end
  end

  assign win_hit  = (paddr >= CTS_WIN_OFF) && (paddr <= CTS_WIN_END);
  assign win_word = WA'(paddr[7:2] - CTS_WIN_OFF[7:2]);
  // refused when nothing selected or the buffer is queued
  assign win_ok   = (sel_onehot != 3'h0)  // R6
                    && |(sel_onehot & tx_buffer_empty_flag_q);  // R5

  // selection register: frozen at reset in init mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buffer_select_q <= CTS_TBSEL_RST;
    end else if (ce) begin
      if (init_mode) begin
        tx_buffer_select_q <= CTS_TBSEL_RST;  // R1
      end else if (access && pwrite && run_mode && paddr == CTS_TBSEL_OFF) begin  // R2
        tx_buffer_select_q <= pwdata[CTS_TBSEL_W-1:0];  // R15
      end
    end
  end

  // empty flags: software clears by writing 1 to schedule, core sets on done.
  // set wins over clear so a completion in the same cycle is never lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buffer_empty_flag_q <= CTS_TXE_RST;
    end else if (ce) begin
      if (init_mode) begin
        tx_buffer_empty_flag_q <= CTS_TXE_RST;
      end else begin
        if (access && pwrite && run_mode && paddr == CTS_TXFLAG_OFF) begin
          tx_buffer_empty_flag_q <= (tx_buffer_empty_flag_q & ~pwdata[2:0]) | tx_done;  // R14
        end else begin
          tx_buffer_empty_flag_q <= tx_buffer_empty_flag_q | tx_done;  // R14
        end
      end
    end
  end

  // transmit window storage, one bank per buffer
  always_ff @(posedge clk) begin
    // a transfer already answered with an error never writes, even if the flag sets meanwhile
    if (ce && access && pwrite && win_hit && win_ok && !pslverr) begin  // R5 R6
      win_mem[sel_idx][win_word] <= pwdata;
    end
  end

  assign org_we = access && pwrite && (paddr == CTS_IDAC_OFF);

  cts_filter_hit u_filter (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .init_mode (init_mode),
    .org_we    (org_we),
    .org_wdata (pwdata[CTS_ORG_LSB+1:CTS_ORG_LSB]),
    .rx_valid  (rx_valid),
    .rx_hit    (rx_hit),
    .org_q     (org_q),
    .hit_q     (hit_q),
    .rx_accept (rx_accept)
  );

  // read mux and error decode; unmapped or refused access gives pslverr
  always_comb begin
    rd_d  = 32'h0;
    err_d = 1'b0;
    if (win_hit) begin
      if (win_ok) begin
        rd_d = pwrite ? 32'h0 : win_mem[sel_idx][win_word];
      end else begin
        err_d = 1'b1;  // R5 R6
      end
    end else begin
      case (paddr)
        CTS_TBSEL_OFF:  rd_d = {29'h0, sel_onehot};  // R3 R7
        CTS_IDAC_OFF:   rd_d = {26'h0, org_q, 1'b0, hit_q};  // R8 R9 R15
        CTS_TXFLAG_OFF: rd_d = {29'h0, tx_buffer_empty_flag_q};  // R14
        CTS_STATUS_OFF: rd_d = {30'h0, init_acknowledge, init_request};
        default:        err_d = 1'b1;
      endcase
    end
  end

  // apb answer registered: pready one enabled cycle after psel, low again after it is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= req_wait;
      pslverr <= req_wait && err_d;
      if (req_wait && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // core-facing status, all from flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_scheduled              <= 3'h0;
      rx_load                   <= 1'b0;
      filter_organisation_field <= CTS_ORG_RST;
      tbsel_mapped              <= 2'h0;
    end else if (ce) begin
      tx_scheduled              <= ~tx_buffer_empty_flag_q;
      rx_load                   <= rx_accept;  // R11
      filter_organisation_field <= org_q;  // R10
      tbsel_mapped              <= sel_idx;
    end
  end

endmodule : cts_txsel_ctrl

//--- design/cts_pkg.sv
package cts_pkg;

  // register byte addresses on the apb slave
  localparam logic [7:0] CTS_TBSEL_OFF   = 8'h00;
  localparam logic [7:0] CTS_IDAC_OFF    = 8'h04;
  localparam logic [7:0] CTS_TXFLAG_OFF  = 8'h08;
  localparam logic [7:0] CTS_STATUS_OFF  = 8'h0c;
  localparam logic [7:0] CTS_WIN_OFF     = 8'h40;  // start of the transmit window
  localparam logic [7:0] CTS_WIN_END     = 8'h7c;  // last word of the window

  // field positions and sizes
  localparam int CTS_TBSEL_W    = 3;
  localparam int CTS_ORG_LSB    = 4;
  localparam int CTS_HIT_LSB    = 0;
  localparam int CTS_WIN_WORDS  = 16;

  // reset values
  localparam logic [2:0] CTS_TBSEL_RST  = 3'h0;
  localparam logic [1:0] CTS_ORG_RST    = 2'h0;
  localparam logic [2:0] CTS_HIT_RST    = 3'h0;
  localparam logic [2:0] CTS_TXE_RST    = 3'h7;

  // filter organisation codes
  typedef enum logic [1:0] {
    CTS_ORG_TWO32   = 2'h0,
    CTS_ORG_FOUR16  = 2'h1,
    CTS_ORG_EIGHT8  = 2'h2,
    CTS_ORG_CLOSED  = 2'h3
  } cts_org_e;

  // lowest set bit only, others cleared
  function automatic logic [2:0] cts_lowest(input logic [2:0] v);
    logic [2:0] r;
    r = 3'h0;
    if (v[0]) begin
      r = 3'h1;
    end else if (v[1]) begin
      r = 3'h2;
    end else if (v[2]) begin
      r = 3'h4;
    end
    return r;
  endfunction : cts_lowest

endpackage : cts_pkg

//--- design/cts_filter_hit.sv
// holds the filter organisation and the hit index of the foreground message
module cts_filter_hit
  import cts_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       init_mode,
  input  wire logic       org_we,
  input  wire logic [1:0] org_wdata,
  input  wire logic       rx_valid,
  input  wire logic [2:0] rx_hit,
  output logic [1:0]      org_q,
  output logic [2:0]      hit_q,
  output logic            rx_accept
);

  // only writable in init mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      org_q <= CTS_ORG_RST;
    end else if (ce && org_we && init_mode) begin  // R8
      org_q <= org_wdata;  // R10
    end
  end

  // closed filter lets nothing through to the foreground buffer
  assign rx_accept = rx_valid && (org_q != CTS_ORG_CLOSED);  // R11

  // hit follows the message entering the foreground; no cpu path writes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit_q <= CTS_HIT_RST;
    end else if (ce && rx_accept) begin  // R13
      hit_q <= rx_hit;  // R9 R12
    end
  end

endmodule : cts_filter_hit

//--- testbench/cts_properties.sv
// watches the apb slave and the receive handshake of the top module
module cts_chk
  import cts_pkg::*;
#(
  parameter int WIN_WORDS = CTS_WIN_WORDS
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        init_request,
  input wire logic        init_acknowledge,
  input wire logic        rx_valid,
  input wire logic        rx_load,
  input wire logic [1:0]  filter_organisation_field
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // setup cycle taken by the slave, then a read of one address
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_rd(a);
    s_setup ##0 (!pwrite && paddr == a);
  endsequence
  // two cycles of init so the selection has surely been cleared
  sequence s_init2;
    (init_request && init_acknowledge && ce) [*2];
  endsequence
  // the organisation copy lags its register by one enabled cycle
  sequence s_settled;
    !(init_request && init_acknowledge) && ce;
  endsequence
  property p_answer; s_setup |=> pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_sel_low;
    s_rd(CTS_TBSEL_OFF) |=> $onehot0(prdata) && prdata[31:3] == 29'h0;
  endproperty
  property p_init_sel; s_init2 ##0 s_rd(CTS_TBSEL_OFF) |=> prdata == 32'h0; endproperty
  property p_idac_zero; s_rd(CTS_IDAC_OFF) |=> prdata[31:6] == 26'h0 && !prdata[3]; endproperty
  // one spare cycle allows for the copy lagging the register
  property p_org_hold;
    (!(init_request && init_acknowledge) && ce) [*2] |=> $stable(filter_organisation_field);
  endproperty
  property p_closed;
    s_settled ##1 (rx_valid && ce && filter_organisation_field == CTS_ORG_CLOSED)
      |=> !rx_load;
  endproperty
  property p_load;
    s_settled ##1 (rx_valid && ce && filter_organisation_field != CTS_ORG_CLOSED)
      |=> rx_load;
  endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_sel_low: assert property (p_sel_low) else $error("selection read not lowest bit");
  a_init_sel: assert property (p_init_sel) else $error("selection not reset in init");
  a_idac_zero: assert property (p_idac_zero) else $error("loose bits not zero");
  a_org_hold: assert property (p_org_hold) else $error("organisation changed");
  a_closed: assert property (p_closed) else $error("load with filter closed");
  a_load: assert property (p_load) else $error("message not loaded");
endmodule : cts_chk

bind cts_txsel_ctrl cts_chk #(.WIN_WORDS(WIN_WORDS)) u_chk (.clk, .rst, .ce, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .init_request, .init_acknowledge, .rx_valid,
  .rx_load, .filter_organisation_field);

//--- testbench/tb.sv
module tb;
  import cts_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        init_request = 1'b0, init_acknowledge = 1'b0, rx_valid = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  tx_done = 3'h0, rx_hit = 3'h0, tx_scheduled;
  logic [1:0]  filter_organisation_field, tbsel_mapped;
  logic        pready, pslverr, rx_load;
  int          failures = 0, tests_run = 0, cycles = 0;
  always #5 clk = ~clk;
  cts_txsel_ctrl uut (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .init_request, .init_acknowledge, .tx_done, .tx_scheduled, .rx_valid,
    .rx_hit, .rx_load, .filter_organisation_field, .tbsel_mapped);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; an idle cycle follows so no signal is driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    if (!wr) check(prdata, exp);
    check({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic mode(input logic rq, input logic ak);
    init_request <= rq;
    init_acknowledge <= ak;
    repeat (2) @(posedge clk);
  endtask : mode
  // one message into the foreground; the load pulse stands in the cycle after rx_valid
  task automatic rx(input logic [2:0] h, input logic ld);
    rx_valid <= 1'b1;
    rx_hit <= h;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
    check({31'h0, rx_load}, {31'h0, ld});
  endtask : rx
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard, far above the roughly 130 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, CTS_TBSEL_OFF, 32'h0, 32'h0, 1'b0);
    apb(1'b0, CTS_TXFLAG_OFF, 32'h0, 32'h7, 1'b0);
    apb(1'b1, CTS_TXFLAG_OFF, 32'h1, 32'h0, 1'b0);
    apb(1'b0, CTS_TXFLAG_OFF, 32'h0, 32'h6, 1'b0);
    check({29'h0, tx_scheduled}, 32'h1);
    apb(1'b1, CTS_TBSEL_OFF, 32'h6, 32'h0, 1'b0);
    apb(1'b0, CTS_TBSEL_OFF, 32'h0, 32'h2, 1'b0);
    check({30'h0, tbsel_mapped}, 32'h1);
    apb(1'b1, CTS_WIN_OFF, 32'h5a, 32'h0, 1'b0);
    apb(1'b0, CTS_WIN_OFF, 32'h0, 32'h5a, 1'b0);
    apb(1'b1, CTS_TBSEL_OFF, 32'h7, 32'h0, 1'b0);
    apb(1'b0, CTS_TBSEL_OFF, 32'h0, 32'h1, 1'b0);
    apb(1'b0, CTS_WIN_OFF, 32'h0, 32'h0, 1'b1);
    apb(1'b1, CTS_WIN_END, 32'h1, 32'h0, 1'b1);
    // a completion while the clock enable is low is not seen: buffer 0 stays queued
    ce <= 1'b0;
    tx_done <= 3'h1;
    @(posedge clk);
    ce <= 1'b1;
    tx_done <= 3'h0;
    @(posedge clk);
    apb(1'b0, CTS_TXFLAG_OFF, 32'h0, 32'h6, 1'b0);
    tx_done <= 3'h1;
    @(posedge clk);
    tx_done <= 3'h0;
    @(posedge clk);
    apb(1'b0, CTS_TXFLAG_OFF, 32'h0, 32'h7, 1'b0);
    apb(1'b1, CTS_TBSEL_OFF, 32'h0, 32'h0, 1'b0);
    apb(1'b0, CTS_WIN_OFF, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    mode(1'b1, 1'b0);
    apb(1'b1, CTS_TBSEL_OFF, 32'h4, 32'h0, 1'b0);
    apb(1'b0, CTS_TBSEL_OFF, 32'h0, 32'h0, 1'b0);
    apb(1'b1, CTS_IDAC_OFF, 32'h30, 32'h0, 1'b0);
    apb(1'b0, CTS_IDAC_OFF, 32'h0, 32'h0, 1'b0);
    mode(1'b0, 1'b0);
    apb(1'b1, CTS_TBSEL_OFF, 32'h2, 32'h0, 1'b0);
    mode(1'b1, 1'b1);
    apb(1'b0, CTS_TBSEL_OFF, 32'h0, 32'h0, 1'b0);
    // every organisation code, with the hit and loose bits written as ones
    for (logic [2:0] m = 3'h0; m < 3'h4; m++) begin
      apb(1'b1, CTS_IDAC_OFF, {24'h0, 2'h3, m[1:0], 4'hf}, 32'h0, 1'b0);
      apb(1'b0, CTS_IDAC_OFF, 32'h0, {26'h0, m[1:0], 4'h0}, 1'b0);
      check({30'h0, filter_organisation_field}, {30'h0, m[1:0]});
    end
    mode(1'b0, 1'b0);
    rx(3'h5, 1'b0);
    apb(1'b0, CTS_IDAC_OFF, 32'h0, 32'h30, 1'b0);
    mode(1'b1, 1'b1);
    apb(1'b1, CTS_IDAC_OFF, 32'h10, 32'h0, 1'b0);
    mode(1'b0, 1'b0);
    rx(3'h5, 1'b1);
    apb(1'b0, CTS_IDAC_OFF, 32'h0, 32'h15, 1'b0);
    rx(3'h2, 1'b1);
    apb(1'b0, CTS_IDAC_OFF, 32'h0, 32'h12, 1'b0);
    tally_and_finish();
  end
endmodule : tb
